// ### verilog/mhc_hours_counter.sv
// Decided for this implementation: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "mhc_defines.svh"

module mhc_hours_counter
  import mhc_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `MHC_TICK_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        clockEnable,
  input  wire logic        monitorIn,
  input  wire logic        loadIn,
  input  wire logic        clearAllIn,
  input  wire logic [15:0] extIntervalHours,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             serviceDue
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic mhc_minutes_t toMinutes(input logic [16:0] hours,
                                             input logic [5:0] mins);
    toMinutes = 24'(hours) * 24'(`MHC_MIN_PER_HOUR) + 24'(mins);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] oldv,
                                        input logic [31:0] newv,
                                        input logic [3:0] be);
    for (int i = 0; i < 4; i++)
      merge[i*8 +: 8] = be[i] ? newv[i*8 +: 8] : oldv[i*8 +: 8];
  endfunction

  localparam mhc_minutes_t IV_MAX =
    24'(`MHC_MAX_IV_HOURS * `MHC_MIN_PER_HOUR + `MHC_MAX_MINUTE);
  localparam mhc_minutes_t OT_MAX =
    24'(`MHC_MAX_OT_HOURS * `MHC_MIN_PER_HOUR);
  localparam mhc_minutes_t OT_PRE_MAX =
    24'(`MHC_MAX_OT_HOURS * `MHC_MIN_PER_HOUR + `MHC_MAX_MINUTE);

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [2:0] syncA;
  logic [2:0] syncB;
  logic       monitor;
  logic       loadLvl;
  logic       clearLvl;
  logic       loadPrev;
  logic       clearPrev;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      syncA <= 3'h0;
      syncB <= 3'h0;
      loadPrev <= 1'b0;
      clearPrev <= 1'b0;
    end else if (clockEnable) begin
      syncA <= {clearAllIn, loadIn, monitorIn};
      syncB <= syncA;
      loadPrev <= syncB[1];
      clearPrev <= syncB[2];
    end
  end

  assign monitor  = syncB[0];
  assign loadLvl  = syncB[1];
  assign clearLvl = syncB[2];
  wire loadRise  = loadLvl & ~loadPrev;
  wire clearRise = clearLvl & ~clearPrev;

  // ****************************************
  // Minute tick
  // ****************************************
  logic tick;

  mhc_minute_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) uTick (
    .clock       (clock),
    .nrst        (nrst),
    .clockEnable (clockEnable),
    .tick        (tick)
  );

  // ****************************************
  // Registers
  // ****************************************
  logic [3:0]   ctrl;
  logic [31:0]  intervalReg;
  mhc_minutes_t opTime;
  mhc_minutes_t timeToGo;
  logic         loaded;
  logic         outQ;
  logic         busAck;

  wire running    = ctrl[`MHC_CTRL_RUN];
  wire idleClear  = ctrl[`MHC_CTRL_IDLECLR];
  wire extSelect  = ctrl[`MHC_CTRL_EXTSEL];

  // External interval is whole hours, clamped into range
  wire [16:0] extHours = (extIntervalHours > 16'd9999) ?
                         17'd9999 : {1'b0, extIntervalHours};
  wire mhc_minutes_t ivFromReg = toMinutes({1'b0, intervalReg[15:0]},
                                           intervalReg[21:16]);
  wire mhc_minutes_t ivRaw = extSelect ? toMinutes(extHours, 6'd0)
                                       : ivFromReg;
  wire mhc_minutes_t interval = (ivRaw > IV_MAX) ? IV_MAX : ivRaw;

  // Interval seen last cycle: a run-time change reloads time-to-go
  mhc_minutes_t ivPrev;
  wire ivChanged = running & (interval != ivPrev);

  // Remainder only for preset offsets; divider is a once-off combinational cost
  wire mhc_minutes_t remainder = (interval == 24'h0) ? 24'h0
                                 : opTime % interval;
  wire mhc_minutes_t derivedTogo = interval - remainder;

  wire countStep  = tick & monitor & running;
  wire opSat      = (opTime >= OT_MAX);
  wire anyReset   = loadLvl | clearLvl;
  wire clearOut   = anyReset | (idleClear & ~monitor);
  wire reloadTogo = loadRise | clearRise | ivChanged;

  wire mhc_minutes_t otHrs  = opTime / 24'd60;
  wire mhc_minutes_t otMin  = opTime % 24'd60;
  wire mhc_minutes_t tgHrs  = timeToGo / 24'd60;
  wire mhc_minutes_t tgMin  = timeToGo % 24'd60;

  // Bus decode; writes land on the edge after the wait state, once waitrequest is low
  wire wrCtrl = avs_write & busAck & (avs_address == `MHC_REG_CTRL);
  wire wrIv   = avs_write & busAck & (avs_address == `MHC_REG_INTERVAL);
  wire wrOt   = avs_write & busAck & (avs_address == `MHC_REG_OPTIME)
                & ~running;
  wire [31:0] ctrlWord = merge({28'h0, ctrl}, avs_writedata,
                               avs_byteenable);
  wire [31:0] ivWord   = merge(intervalReg, avs_writedata, avs_byteenable);
  // Fields clamp apart so readback never shows an out-of-range value
  wire [15:0] ivHrsIn  = (ivWord[15:0] > 16'(`MHC_MAX_IV_HOURS)) ?
                         16'(`MHC_MAX_IV_HOURS) : ivWord[15:0];
  wire [5:0]  ivMinIn  = (ivWord[21:16] > 6'(`MHC_MAX_MINUTE)) ?
                         6'(`MHC_MAX_MINUTE) : ivWord[21:16];
  // Byte lanes merge against the readback format, not raw minutes
  wire [31:0] otWord = merge({9'h0, otMin[5:0], otHrs[16:0]},
                             avs_writedata, avs_byteenable);
  wire mhc_minutes_t otPre = toMinutes(otWord[16:0], otWord[22:17]);

  // Counters are plain flops; retention relies on a backed supply
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctrl        <= `MHC_CTRL_RESET;
      intervalReg <= 32'h0;
      opTime      <= 24'h0;
      timeToGo    <= 24'h0;
      ivPrev      <= 24'h0;
      loaded      <= 1'b0;
      outQ        <= 1'b0;
    end else if (clockEnable) begin
      ivPrev <= interval;
      if (wrCtrl)
        ctrl <= ctrlWord[3:0];
      if (wrIv)
        intervalReg <= {10'h0, ivMinIn, ivHrsIn};
      // Operating time: preset, clear-all, or count up to the limit
      if (wrOt)
        opTime <= (otPre > OT_PRE_MAX) ? OT_PRE_MAX : otPre;
      else if (clearRise)
        opTime <= 24'h0;
      else if (countStep & ~opSat)
        opTime <= opTime + 24'h1;
      // Time-to-go
      if (reloadTogo) begin
        timeToGo <= interval;
        loaded   <= 1'b1;
      end else if (!running && !loaded)
        timeToGo <= derivedTogo;
      else if (countStep && timeToGo != 24'h0)
        timeToGo <= timeToGo - 24'h1;
      // Output: clears dominate while a reset input is held
      if (clearOut)
        outQ <= 1'b0;
      else if (running && timeToGo == 24'h0)
        outQ <= 1'b1;
    end
  end

  assign serviceDue = outQ;

  // ****************************************
  // Avalon slave, one wait state
  // ****************************************
  wire [31:0] rdMux =
    (avs_address == `MHC_REG_CTRL) ?
      {22'h0, opSat, outQ, 4'h0, ctrl} :
    (avs_address == `MHC_REG_INTERVAL) ? {10'h0, intervalReg[21:0]} :
    (avs_address == `MHC_REG_OPTIME) ?
      {9'h0, otMin[5:0], otHrs[16:0]} :
    (avs_address == `MHC_REG_TOGO) ?
      {9'h0, tgMin[5:0], tgHrs[16:0]} : 32'h0;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      busAck       <= 1'b0;
      avs_readdata <= 32'h0;
    end else if (clockEnable) begin
      busAck       <= (avs_read | avs_write) & ~busAck;
      // Captured once per read so data stands until the next one
      if (avs_read & ~busAck)
        avs_readdata <= rdMux;
    end
  end

  assign avs_waitrequest = (avs_read | avs_write) & ~busAck;

endmodule

// ### verilog/mhc_defines.svh
`ifndef MHC_DEFINES_SVH
`define MHC_DEFINES_SVH

// Register byte offsets
`define MHC_REG_CTRL      4'h0
`define MHC_REG_INTERVAL  4'h4
`define MHC_REG_OPTIME    4'h8
`define MHC_REG_TOGO      4'hc

// Control register fields
`define MHC_CTRL_RUN      0
`define MHC_CTRL_IDLECLR  1
`define MHC_CTRL_EXTSEL   2
`define MHC_CTRL_PRESET   3

// Status bits in control read
`define MHC_STAT_OUT      8
`define MHC_STAT_SAT      9

// Reset values
`define MHC_CTRL_RESET    4'h0

// Limits in hours and minutes
`define MHC_MIN_PER_HOUR  60
`define MHC_MAX_IV_HOURS  9999
`define MHC_MAX_OT_HOURS  99999
`define MHC_MAX_MINUTE    59

// Timing
`define MHC_CLOCK_HZ      40000000
`define MHC_TICK_SECONDS  60
`define MHC_TICK_CYCLES   (`MHC_CLOCK_HZ * `MHC_TICK_SECONDS)

`endif

// ### verilog/mhc_pkg.sv
package mhc_pkg;

  typedef logic [23:0] mhc_minutes_t;

  typedef enum logic [0:0] {
    MHC_CLR_RESET_ONLY = 1'b0,
    MHC_CLR_RESET_IDLE = 1'b1
  } mhc_clrmode_e;

  typedef enum logic [1:0] {
    MHC_BUS_IDLE = 2'b00,
    MHC_BUS_ACK  = 2'b01
  } mhc_bus_e;

endpackage

// ### verilog/mhc_minute_tick.sv
`timescale 1ns/1ps
`include "mhc_defines.svh"

module mhc_minute_tick
  import mhc_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `MHC_TICK_CYCLES
) (
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic clockEnable,
  output logic      tick
);

  logic [31:0] count;
  wire         atEnd = (count == 32'(TICK_CYCLES - 1));

  // Free-running so one minute is never lost to idle stretches
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      count <= 32'h0;
      tick  <= 1'b0;
    end else if (clockEnable) begin
      count <= atEnd ? 32'h0 : count + 32'h1;
      tick  <= atEnd;
    end
  end

endmodule

// ### dv/mhc_hours_counter_asserts.sv
`timescale 1ns/1ps
// ****
// Port checks
// ****
module mhc_hours_counter_asserts (
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic        loadIn,
  input wire logic        clearAllIn,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        serviceDue
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // Edge path is 2 sync flops plus output flop
  a_load_clears: assert property (
    $rose(loadIn) |-> ##[1:6] !serviceDue) else $error("load kept output");
  a_load_holds: assert property (
    loadIn [*6] |-> !serviceDue) else $error("output set during load");
  a_clear_clears: assert property (
    $rose(clearAllIn) |-> ##[1:6] !serviceDue) else $error("clear kept output");
  a_clear_holds: assert property (
    clearAllIn [*6] |-> !serviceDue) else $error("output set during clear");
  a_reset_quiet: assert property (
    $rose(nrst) |-> !serviceDue && avs_readdata == 32'h0) else $error("reset");
  a_wait_first: assert property (
    $rose(avs_read | avs_write) |-> avs_waitrequest) else $error("no wait");
  a_wait_ends: assert property (
    avs_read && avs_waitrequest |=> !avs_waitrequest) else $error("long wait");
  a_rdata_steady: assert property (
    !avs_read && !$past(avs_read) |-> $stable(avs_readdata))
    else $error("read data moved");
endmodule

// ### dv/mhc_peer.sv
`timescale 1ns/1ps
// ****
// Neighbouring logic blocks
// ****
module mhc_peer (
  input wire logic   clock,
  output logic        monitorIn,
  output logic        loadIn,
  output logic        clearAllIn,
  output logic [15:0] extIntervalHours
);
  // Whole hours, normally inside 0..9999
  initial extIntervalHours = 16'h0;
  initial monitorIn = 1'b0;
  initial loadIn = 1'b0;
  initial clearAllIn = 1'b0;
  // Levels held long enough to pass the input synchronisers
  task automatic pulse(input logic all, input int len);
    @(posedge clock);
    if (all) clearAllIn <= 1'b1;
    else loadIn <= 1'b1;
    repeat (len) @(posedge clock);
    clearAllIn <= 1'b0;
    loadIn <= 1'b0;
    repeat (6) @(posedge clock);
  endtask
  task automatic setExt(input logic [15:0] h);
    @(posedge clock);
    extIntervalHours <= h;
  endtask
  task automatic setMon(input logic v);
    @(posedge clock);
    monitorIn <= v;
    repeat (6) @(posedge clock);
  endtask
endmodule

// ### dv/mhc_hours_counter_tb.sv
`timescale 1ns/1ps
module mhc_hours_counter_tb;
  logic        clock, nrst, avs_read, avs_write, avs_waitrequest;
  logic        monitorIn, loadIn, clearAllIn, serviceDue;
  logic [15:0] extIntervalHours;
  logic [3:0]  avs_address, avs_byteenable;
  logic        clockEnable;
  logic [31:0] avs_writedata, avs_readdata, rd, o;
  int          nMismatch, comparisons;
  // ****
  // Design and neighbours
  // ****
  mhc_hours_counter #(.TICK_CYCLES(10)) i_dut (.clock(clock), .nrst(nrst),
    .clockEnable(clockEnable), .monitorIn(monitorIn), .loadIn(loadIn),
    .clearAllIn(clearAllIn), .extIntervalHours(extIntervalHours),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .serviceDue(serviceDue));
  mhc_peer i_peer (.clock(clock), .monitorIn(monitorIn), .loadIn(loadIn),
    .clearAllIn(clearAllIn), .extIntervalHours(extIntervalHours));
  // ****
  // Shared tasks
  // ****
  task automatic reportAndStop;
    if (nMismatch == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      nMismatch++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic int unsigned mins(input logic [31:0] v);
    return v[16:0] * 60 + v[22:17];
  endfunction
  // Request stands until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int  k;
    k = 0;
    avs_address <= a;
    avs_writedata <= d;
    if (w) avs_write <= 1'b1;
    else avs_read <= 1'b1;
    do begin
      @(posedge clock);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
    if (k >= 20) begin
      nMismatch++;
      reportAndStop;
    end
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic q(input logic e);
    @(negedge clock);
    chk(32'(serviceDue), 32'(e));
    @(posedge clock);
  endtask
  // ****
  // Scenarios
  // ****
  task automatic tRegs;
    rdc(4'h0, 32'h0);
    rdc(4'h2, 32'h0);
    bus(1'b1, 4'h4, 32'h003fffff);
    rdc(4'h4, 32'h003b270f);
  endtask
  task automatic tPreset;
    bus(1'b1, 4'h4, 32'h1e);
    bus(1'b1, 4'h8, 32'h64);
    rdc(4'hc, 32'h14);
    bus(1'b1, 4'h0, 32'h1);
    bus(1'b1, 4'h8, 32'h7);
    rdc(4'h8, 32'h64);
  endtask
  task automatic tCount;
    int k;
    bus(1'b1, 4'h4, 32'h00030000);
    i_peer.setMon(1'b1);
    for (k = 0; k < 400 && serviceDue !== 1'b1; k++) @(negedge clock);
    @(posedge clock);
    q(1'b1);
    rdc(4'hc, 32'h0);
    i_peer.setMon(1'b0);
    bus(1'b0, 4'h8, 32'h0);
    o = rd;
    repeat (60) @(posedge clock);
    rdc(4'h8, o);
    q(1'b1);
    bus(1'b1, 4'h0, 32'h3);
    q(1'b0);
    bus(1'b1, 4'h0, 32'h1);
    q(1'b1);
  endtask
  task automatic tLoad;
    bus(1'b1, 4'h4, 32'h5);
    rdc(4'hc, 32'h5);
    bus(1'b0, 4'h8, 32'h0);
    o = rd;
    i_peer.pulse(1'b0, 6);
    q(1'b0);
    rdc(4'h8, o);
    i_peer.setMon(1'b1);
    i_peer.pulse(1'b0, 40);
    i_peer.setMon(1'b0);
    bus(1'b0, 4'h8, 32'h0);
    chk(32'(rd > o), 32'h1);
    i_peer.pulse(1'b1, 6);
    q(1'b0);
    rdc(4'h8, 32'h0);
    rdc(4'hc, 32'h5);
  endtask
  task automatic tExtSat;
    bus(1'b1, 4'h0, 32'h5);
    i_peer.setExt(16'hc);
    i_peer.pulse(1'b0, 6);
    rdc(4'hc, 32'hc);
    bus(1'b1, 4'h0, 32'h0);
    bus(1'b1, 4'h8, 32'h1869f);
    bus(1'b1, 4'h0, 32'h1);
    i_peer.setMon(1'b1);
    repeat (60) @(posedge clock);
    rdc(4'h8, 32'h1869f);
    bus(1'b0, 4'h0, 32'h0);
    chk(32'(rd[9]), 32'h1);
  endtask
  task automatic tEnable;
    logic [31:0] t0;
    avs_byteenable <= 4'h1;
    bus(1'b1, 4'h4, 32'hffffff07);
    avs_byteenable <= 4'hf;
    rdc(4'h4, 32'h7);
    avs_byteenable <= 4'h4;
    bus(1'b1, 4'h4, 32'h00050000);
    avs_byteenable <= 4'hf;
    rdc(4'h4, 32'h00050007);
    bus(1'b0, 4'hc, 32'h0);
    t0 = rd;
    clockEnable <= 1'b0;
    repeat (200) @(posedge clock);
    clockEnable <= 1'b1;
    bus(1'b0, 4'hc, 32'h0);
    chk(32'(mins(t0) - mins(rd) < 2), 32'h1);
    t0 = rd;
    repeat (200) @(posedge clock);
    bus(1'b0, 4'hc, 32'h0);
    chk(32'(mins(t0) - mins(rd) > 10), 32'h1);
  endtask
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    nrst = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    clockEnable = 1'b1;
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    tRegs;
    tPreset;
    tCount;
    tLoad;
    tExtSat;
    tEnable;
    reportAndStop;
  end
endmodule
bind mhc_hours_counter mhc_hours_counter_asserts i_chk (.clock(clock),
  .nrst(nrst), .loadIn(loadIn), .clearAllIn(clearAllIn),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .serviceDue(serviceDue));
